// File: core/btse_pkg.sv
// Constants and types for the bit-test-and-skip execution block
package btse_pkg;

    // ----------------------------------------
    // Instruction fields
    // ----------------------------------------
    localparam logic [3:0] OPC_SKIP_CLEAR = 4'h_b;
    localparam logic [3:0] OPC_SKIP_SET = 4'h_a;
    localparam int OPC_POS = 12;
    localparam int BIT_POS = 9;
    localparam int ACC_POS = 8;
    localparam logic [7:0] INDEXED_LIMIT = 8'h_5f;
    localparam logic [7:0] ACCESS_SPLIT = 8'h_60;
    localparam logic [3:0] ACCESS_HIGH_BANK = 4'h_f;
    localparam logic [15:0] NOP_WORD = 16'h_0000;

    // ----------------------------------------
    // Reset values
    // ----------------------------------------
    localparam logic [1:0] QPH_RST = 2'h_0;
    localparam logic [15:0] WORD_RST = 16'h_0000;
    localparam logic [11:0] ADDR_RST = 12'h_000;

    typedef enum logic [1:0] {
        QPH_DECODE = 2'b00,
        QPH_READ = 2'b01,
        QPH_PROCESS = 2'b10,
        QPH_WRITE = 2'b11
    } btse_qph_t;

endpackage

// File: core/btse_dec_if.sv
// Decoded fields passed from the decoder to the executing stage
`timescale 1ns/1ps
`default_nettype none
interface btse_dec_if;
    logic is_test;
    logic want_set;
    logic [2:0] bit_idx;
    logic [11:0] addr;
    modport dec (output is_test, output want_set, output bit_idx, output addr);
    modport exe (input is_test, input want_set, input bit_idx, input addr);
endinterface
`default_nettype wire

// File: core/btse_decoder.sv
// Combinational decode of the bit-test instruction word
`timescale 1ns/1ps
`default_nettype none
module btse_decoder (
    input wire logic [15:0] instr_i,
    input wire logic [3:0] bank_sel_i,
    input wire logic ext_set_i,
    input wire logic [11:0] fsr2_i,
    btse_dec_if.dec dec
);
    logic [3:0] opc;
    logic acc;
    logic [7:0] f;

    always_comb
    begin
        opc = instr_i[btse_pkg::OPC_POS +: 4];
        acc = instr_i[btse_pkg::ACC_POS];
        f = instr_i[7:0];
        dec.is_test = (opc == btse_pkg::OPC_SKIP_CLEAR) || (opc == btse_pkg::OPC_SKIP_SET);
        dec.want_set = (opc == btse_pkg::OPC_SKIP_SET);
        dec.bit_idx = instr_i[btse_pkg::BIT_POS +: 3];
        if (acc)
        begin
            dec.addr = {bank_sel_i, f};
        end
        else if (ext_set_i && (f <= btse_pkg::INDEXED_LIMIT))
        begin
            // Offset from the frame pointer, wraps inside data space
            dec.addr = 12'(fsr2_i + {4'h_0, f});
        end
        else if (f < btse_pkg::ACCESS_SPLIT)
        begin
            dec.addr = {4'h_0, f};
        end
        else
        begin
            dec.addr = {btse_pkg::ACCESS_HIGH_BANK, f};
        end
    end
endmodule
`default_nettype wire

// File: core/btse_core.sv
// Bit-test-and-skip execution stage, clocked by the quarter phases
`timescale 1ns/1ps
`default_nettype none
module btse_core (
    input wire logic ref_clk_i,
    input wire logic nrst_i,
    input wire logic q_adv_i,
    input wire logic [15:0] fetched_i,
    input wire logic [3:0] bank_sel_i,
    input wire logic ext_set_i,
    input wire logic [11:0] fsr2_i,
    input wire logic [7:0] rd_data_i,
    output logic [11:0] rd_addr_o,
    output logic rd_en_o,
    output logic [15:0] exec_word_o,
    output logic skip_o,
    output logic [1:0] q_phase_o
);
    // ----------------------------------------
    // Decode
    // ----------------------------------------
    btse_dec_if dif ();
    btse_pkg::btse_qph_t q_q;
    btse_pkg::btse_qph_t q_d;
    logic adv_decode;
    logic adv_read;
    logic adv_process;
    logic adv_write;
    logic [15:0] ir_q;
    logic [15:0] ir_d;
    logic kill_q;
    logic kill_d;
    logic test_q;
    logic test_d;
    logic set_q;
    logic set_d;
    logic [2:0] bit_q;
    logic [2:0] bit_d;
    logic [11:0] addr_q;
    logic [11:0] addr_d;
    logic rd_en_q;
    logic rd_en_d;
    logic skip_q;
    logic skip_d;
    logic hit;

    btse_decoder u_dec (
        .instr_i(ir_q),
        .bank_sel_i(bank_sel_i),
        .ext_set_i(ext_set_i),
        .fsr2_i(fsr2_i),
        .dec(dif)
    );

    // ----------------------------------------
    // Quarter phase sequencing
    // ----------------------------------------
    // Quarters wrap from Q4 back to Q1 with no idle state between them
    function automatic btse_pkg::btse_qph_t next_phase(input btse_pkg::btse_qph_t q);
        btse_pkg::btse_qph_t n;
        n = q;
        unique case (q)
            btse_pkg::QPH_DECODE:
            begin
                n = btse_pkg::QPH_READ;
            end
            btse_pkg::QPH_READ:
            begin
                n = btse_pkg::QPH_PROCESS;
            end
            btse_pkg::QPH_PROCESS:
            begin
                n = btse_pkg::QPH_WRITE;
            end
            btse_pkg::QPH_WRITE:
            begin
                n = btse_pkg::QPH_DECODE;
            end
        endcase
        return n;
    endfunction

    // One strobe per quarter keeps each group below tied to a single phase, except the skip decision, which uses Q2 and Q3
    always_comb
    begin
        adv_decode = 1'h_0;
        adv_read = 1'h_0;
        adv_process = 1'h_0;
        adv_write = 1'h_0;
        q_d = q_q;
        if (q_adv_i)
        begin
            q_d = next_phase(q_q);
            unique case (q_q)
                btse_pkg::QPH_DECODE:
                begin
                    adv_decode = 1'h_1;
                end
                btse_pkg::QPH_READ:
                begin
                    adv_read = 1'h_1;
                end
                btse_pkg::QPH_PROCESS:
                begin
                    adv_process = 1'h_1;
                end
                btse_pkg::QPH_WRITE:
                begin
                    adv_write = 1'h_1;
                end
            endcase
        end
    end

    always_ff @(posedge ref_clk_i or negedge nrst_i)
    begin
        if (!nrst_i)
        begin
            q_q <= btse_pkg::btse_qph_t'(btse_pkg::QPH_RST);
        end
        else
        begin
            q_q <= q_d;
        end
    end

    // ----------------------------------------
    // Operand capture
    // ----------------------------------------
    // Fields are frozen at Q1 so a later word change cannot move the read
    always_comb
    begin
        test_d = test_q;
        set_d = set_q;
        bit_d = bit_q;
        addr_d = addr_q;
        rd_en_d = 1'h_0;
        if (adv_decode)
        begin
            test_d = dif.is_test;
            set_d = dif.want_set;
            bit_d = dif.bit_idx;
            addr_d = dif.addr;
            rd_en_d = dif.is_test;
        end
    end

    always_ff @(posedge ref_clk_i or negedge nrst_i)
    begin
        if (!nrst_i)
        begin
            test_q <= 1'h_0;
            set_q <= 1'h_0;
            bit_q <= 3'h_0;
            addr_q <= btse_pkg::ADDR_RST;
            rd_en_q <= 1'h_0;
        end
        else
        begin
            test_q <= test_d;
            set_q <= set_d;
            bit_q <= bit_d;
            addr_q <= addr_d;
            rd_en_q <= rd_en_d;
        end
    end

    // ----------------------------------------
    // Skip decision
    // ----------------------------------------
    always_comb
    begin
        skip_d = skip_q;
        hit = rd_data_i[bit_q] == set_q;
        if (adv_read)
        begin
            skip_d = 1'h_0;
        end
        else if (adv_process)
        begin
            // Data sampled here, one phase after the read strobe
            skip_d = test_q && hit;
        end
    end

    always_ff @(posedge ref_clk_i or negedge nrst_i)
    begin
        if (!nrst_i)
        begin
            skip_q <= 1'h_0;
        end
        else
        begin
            skip_q <= skip_d;
        end
    end

    // ----------------------------------------
    // Instruction register
    // ----------------------------------------
    // Two-word followers are not handled: only one word is ever dropped
    always_comb
    begin
        ir_d = ir_q;
        kill_d = kill_q;
        if (adv_write)
        begin
            // Prefetched word is replaced, so a skip costs a full cycle
            if (skip_q)
            begin
                ir_d = btse_pkg::NOP_WORD;
                kill_d = 1'h_1;
            end
            else
            begin
                ir_d = fetched_i;
                kill_d = 1'h_0;
            end
        end
    end

    always_ff @(posedge ref_clk_i or negedge nrst_i)
    begin
        if (!nrst_i)
        begin
            ir_q <= btse_pkg::WORD_RST;
            kill_q <= 1'h_0;
        end
        else
        begin
            ir_q <= ir_d;
            kill_q <= kill_d;
        end
    end

    // ----------------------------------------
    // Outputs
    // ----------------------------------------
    assign rd_addr_o = addr_q;
    assign rd_en_o = rd_en_q;
    assign exec_word_o = ir_q;
    assign skip_o = kill_q;
    assign q_phase_o = q_q;
endmodule
`default_nettype wire

// File: testbench/btse_core_properties.sv
// Checker for the bit-test-and-skip stage
`timescale 1ns/1ps
`default_nettype none
module btse_core_properties (
    input wire logic ref_clk_i,
    input wire logic nrst_i,
    input wire logic q_adv_i,
    input wire logic [3:0] bank_sel_i,
    input wire logic ext_set_i,
    input wire logic [11:0] fsr2_i,
    input wire logic [7:0] rd_data_i,
    input wire logic [11:0] rd_addr_o,
    input wire logic rd_en_o,
    input wire logic [15:0] exec_word_o,
    input wire logic skip_o,
    input wire logic [1:0] q_phase_o
);
    // ----
    // Checks
    // ----
    logic q1, q3, q4, tst, take, idx, take_q;
    assign q1 = q_adv_i && q_phase_o == 2'h_0;
    assign q3 = q_adv_i && q_phase_o == 2'h_2;
    assign q4 = q_adv_i && q_phase_o == 2'h_3;
    assign tst = exec_word_o[15:13] == 3'h_5;
    assign take = tst && (rd_data_i[exec_word_o[11:9]] != exec_word_o[12]);
    assign idx = ext_set_i && exec_word_o[7:0] <= 8'h_5f;
    // Bit state as it stood at the Q3 advance, where the decision is made
    always_ff @(posedge ref_clk_i or negedge nrst_i)
    begin
        if (!nrst_i)
        begin
            take_q <= 1'h_0;
        end
        else if (q3)
        begin
            take_q <= take;
        end
    end
    default clocking cb @(posedge ref_clk_i);
    endclocking
    default disable iff (!nrst_i);
    a_read_on_test: assert property (q1 && tst |=> rd_en_o)
        else $error("Read strobe missing after a bit test decode");
    a_no_read_other: assert property (q1 && !tst |=> !rd_en_o)
        else $error("Read strobe raised for an opcode that is not a bit test");
    a_access_bank: assert property (rd_en_o && !exec_word_o[8] && !idx |->
        rd_addr_o == {{4{exec_word_o[7:0] > 8'h_5f}}, exec_word_o[7:0]})
        else $error("Access bank address wrong");
    a_banked_addr: assert property (rd_en_o && exec_word_o[8] |->
        rd_addr_o == {bank_sel_i, exec_word_o[7:0]})
        else $error("Banked address wrong");
    a_indexed_addr: assert property (rd_en_o && !exec_word_o[8] && idx |->
        rd_addr_o == fsr2_i + {4'h_0, exec_word_o[7:0]})
        else $error("Indexed address wrong");
    a_skip_taken: assert property (q4 && take_q |=> skip_o && exec_word_o == 16'h_0000)
        else $error("Skip not taken or follower not replaced");
    a_skip_absent: assert property (q4 && !take_q |=> !skip_o)
        else $error("Skip taken without its condition");
    c_skip: cover property (q4 && take_q);
    c_pass: cover property (q4 && tst && !take_q);
    c_bank: cover property (rd_en_o && exec_word_o[8]);
endmodule
bind btse_core btse_core_properties u_props (.ref_clk_i, .nrst_i, .q_adv_i, .bank_sel_i,
    .ext_set_i, .fsr2_i, .rd_data_i, .rd_addr_o, .rd_en_o, .exec_word_o, .skip_o, .q_phase_o);
`default_nettype wire

// File: testbench/testbench.sv
// Self-checking bench for the bit-test-and-skip stage
`timescale 1ns/1ps
`default_nettype none
module testbench;
    logic ref_clk_i, nrst_i, q_adv_i, ext_set_i, rd_en_o, skip_o;
    logic [15:0] fetched_i, exec_word_o;
    logic [11:0] fsr2_i, rd_addr_o;
    logic [7:0] rd_data_i;
    logic [3:0] bank_sel_i;
    logic [1:0] q_phase_o;
    int miscompares = 0;
    int checked = 0;
    btse_core DUT (.ref_clk_i, .nrst_i, .q_adv_i, .fetched_i, .bank_sel_i, .ext_set_i,
        .fsr2_i, .rd_data_i, .rd_addr_o, .rd_en_o, .exec_word_o, .skip_o, .q_phase_o);
    // ----
    // Tasks
    // ----
    task automatic chk(input logic [15:0] got, input logic [15:0] exp);
        checked++;
        if (got !== exp)
        begin
            miscompares++;
            $display("ERROR t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask
    task automatic complete_run();
        $display("miscompares=%0d checked=%0d", miscompares, checked);
        if (miscompares == 0 && checked > 0)
            $display("Run complete: PASS");
        else
            $display("Run complete: FAIL");
        $finish;
    endtask
    // Data held over Q3 and Q4 so the sampled bit is unambiguous
    task automatic step(input logic [15:0] w, input logic [7:0] d, input logic [11:0] a,
        input logic s);
        int n;
        n = 0;
        while (q_phase_o !== 2'h_3)
        begin
            @(posedge ref_clk_i) #1;
            n++;
            if (n > 8)
            begin
                miscompares++;
                complete_run();
            end
        end
        fetched_i = w;
        rd_data_i = d;
        @(posedge ref_clk_i) #1;
        fetched_i = 16'h_1234;
        @(posedge ref_clk_i) #1;
        chk({3'h_0, rd_en_o, rd_addr_o}, {4'h_1, a});
        @(posedge ref_clk_i) #1;
        chk({3'h_0, rd_en_o, rd_addr_o}, {4'h_0, a});
        repeat (2) @(posedge ref_clk_i) #1;
        chk(exec_word_o, s ? 16'h_0000 : 16'h_1234);
        chk({15'h_0000, skip_o}, {15'h_0000, s});
        chk({14'h_0000, q_phase_o}, 16'h_0000);
    endtask
    task automatic sc_access();
        ext_set_i = 1'h_0;
        step(16'h_ae20, 8'h_80, 12'h_020, 1'h_1);
        step(16'h_ae20, 8'h_7f, 12'h_020, 1'h_0);
        step(16'h_b070, 8'h_fe, 12'h_f70, 1'h_1);
        step(16'h_b070, 8'h_01, 12'h_f70, 1'h_0);
    endtask
    task automatic sc_bank();
        ext_set_i = 1'h_1;
        bank_sel_i = 4'h_5;
        step(16'h_a745, 8'h_08, 12'h_545, 1'h_1);
    endtask
    task automatic sc_indexed();
        fsr2_i = 12'h_ff0;
        step(16'h_b45f, 8'h_04, 12'h_04f, 1'h_0);
        step(16'h_b460, 8'h_00, 12'h_f60, 1'h_1);
    endtask
    initial
    begin
        ref_clk_i = 1'h_0;
        forever #5 ref_clk_i = ~ref_clk_i;
    end
    initial
    begin
        nrst_i = 1'h_0;
        q_adv_i = 1'h_0;
        ext_set_i = 1'h_0;
        fetched_i = '0;
        bank_sel_i = '0;
        fsr2_i = '0;
        rd_data_i = '0;
        repeat (4) @(posedge ref_clk_i);
        #1 nrst_i = 1'h_1;
        q_adv_i = 1'h_1;
        sc_access();
        sc_bank();
        sc_indexed();
        complete_run();
    end
endmodule
`default_nettype wire
